// ==== logic/nbe_pkg.sv ====
/*
 holds the shared constants of the memory bit-error reporting pair: control
 bit positions, flag positions, vector codes, widths and timing counts.
 assumes both ends and the link interface import it.
*/
package nbe_pkg;
    // enable bits of the general control register a
    localparam int CTL_A_W = 3;
    localparam int BIT_UNCORR_RST = 0;
    localparam int BIT_UNCORR_IRQ = 1;
    localparam int BIT_CORR_IRQ = 2;
    localparam logic [CTL_A_W-1:0] CTL_A_RESET = 3'h0;
    // error flags of the general control register b
    localparam int FLAG_W = 2;
    localparam int FLAG_UNCORR = 0;
    localparam int FLAG_CORR = 1;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 2'h0;
    localparam logic [FLAG_W-1:0] FLAG_ALL = 2'h3;
    // vector codes; the non-zero values are arbitrary
    localparam int VEC_W = 5;
    localparam logic [VEC_W-1:0] RSTVEC_NONE = 5'h00;
    localparam logic [VEC_W-1:0] RSTVEC_UNCORR = 5'h1c;
    localparam logic [VEC_W-1:0] NMIVEC_NONE = 5'h00;
    localparam logic [VEC_W-1:0] NMIVEC_UNCORR = 5'h02;
    localparam logic [VEC_W-1:0] NMIVEC_CORR = 5'h04;
    // clocking
    localparam int CLK_HZ = 20_000_000;
    localparam int UNCORR_RST_MAX_HZ = 12_000_000;
    localparam int PUC_CYCLES = 4;
    localparam int PUC_CNT_W = 3;
    // status widths
    localparam int ADDR_W = 16;
    localparam int ERR_CNT_W = 8;
endpackage

// ==== logic/nbe_link_if.sv ====
/*
 holds the link between the error-reporting logic and the fetching core.
 assumes one clock, clk_sys, shared by both ends.
*/
interface nbe_link_if;
    import nbe_pkg::*;
    logic enWrite;
    logic [CTL_A_W-1:0] enData;
    logic [FLAG_W-1:0] flagClear;
    logic nmiAck;
    logic rstVecRead;
    logic [CTL_A_W-1:0] enables;
    logic [FLAG_W-1:0] flags;
    logic nmiReq;
    logic [VEC_W-1:0] nmiVector;
    logic pucReq;
    logic [VEC_W-1:0] rstVector;
    modport dev (
        input enWrite, enData, flagClear, nmiAck, rstVecRead,
        output enables, flags, nmiReq, nmiVector, pucReq, rstVector
    );
    modport core (
        output enWrite, enData, flagClear, nmiAck, rstVecRead,
        input enables, flags, nmiReq, nmiVector, pucReq, rstVector
    );
endinterface

// ==== logic/nbe_error_report.sv ====
/*
 holds the memory-side end: enables, sticky error flags, nmi vector and
 power-up-clear request with its reset source vector.
 assumes error strobes come from the memory checker synchronous to clk_sys and
 that this block's own reset is the power-on reset, not the power-up clear;
 pucHold goes to the system reset logic and must never reset this block.
 // Function
 //(RULE1) uncorrectable error with reset enable triggers clear
 //(RULE2) clear leaves uncorrectable code in reset vector
 //(RULE3) uncorrectable error with enable raises nmi, posts code
 //(RULE4) correctable error with enable raises nmi, posts code
 //(RULE5) separate sticky flags held until software clears
 //(RULE6) software disables enables around low power modes
 //(RULE7) software keeps clock at most 12 MHz
 //(RULE8) software ignores resets with zero reset vector
 //(RULE9) reset and interrupt paths gated independently
 //(RULE10) flags set on detection regardless of enables
*/
module nbe_error_report (
    input wire logic clk_sys,
    input wire logic reset,
    nbe_link_if.dev link,
    input wire logic corrErrDet,
    input wire logic uncorrErrDet,
    input wire logic [nbe_pkg::ADDR_W-1:0] errAddr,
    output logic pucHold,
    output logic [nbe_pkg::ADDR_W-1:0] lastErrAddr,
    output logic [nbe_pkg::ERR_CNT_W-1:0] corrCount,
    output logic [nbe_pkg::ERR_CNT_W-1:0] uncorrCount
);
    import nbe_pkg::*;

    logic [CTL_A_W-1:0] enables_reg;
    logic [CTL_A_W-1:0] enables_next;
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] flags_next;
    logic [FLAG_W-1:0] detect;
    logic pendUncorr_reg;
    logic pendUncorr_next;
    logic pendCorr_reg;
    logic pendCorr_next;
    logic [VEC_W-1:0] nmiVec_reg;
    logic [VEC_W-1:0] nmiVec_next;
    logic [PUC_CNT_W-1:0] pucCnt_reg;
    logic [PUC_CNT_W-1:0] pucCnt_next;
    logic pucHold_reg;
    logic [VEC_W-1:0] rstVec_reg;
    logic [VEC_W-1:0] rstVec_next;
    logic [ADDR_W-1:0] errAddr_reg;
    logic [ADDR_W-1:0] errAddr_next;
    logic [ERR_CNT_W-1:0] errCnt_reg [FLAG_W];
    logic [ERR_CNT_W-1:0] errCnt_next [FLAG_W];
    logic [FLAG_W-1:0] cntFull;
    logic uncorrNmiTrig;
    logic corrNmiTrig;
    logic pucTrig;
    logic ackUncorr;
    logic ackCorr;
    logic rstEn;
    logic uncorrIrqEn;
    logic corrIrqEn;
    logic anyDetect;
    logic pucActive;
    logic pucActiveNext;
    logic nmiPending;

    localparam logic [PUC_CNT_W-1:0] PUC_LOAD = PUC_CNT_W'(PUC_CYCLES);
    localparam logic [PUC_CNT_W-1:0] PUC_ONE = 3'h1;
    localparam logic [PUC_CNT_W-1:0] PUC_ZERO = 3'h0;
    localparam logic [ERR_CNT_W-1:0] CNT_ONE = 8'h01;

    assign detect[FLAG_UNCORR] = uncorrErrDet;
    assign detect[FLAG_CORR] = corrErrDet;

    assign enables_next = link.enWrite ? link.enData : enables_reg;

    // each flag is its own sticky bit; a detection in the clearing cycle wins
    genvar i;
    generate
        for (i = 0; i < FLAG_W; i++)
        begin : g_flag
            assign flags_next[i] = detect[i] | (flags_reg[i] & ~link.flagClear[i]); // RULE5 RULE10
        end
    endgenerate

    assign rstEn = enables_reg[BIT_UNCORR_RST];
    assign uncorrIrqEn = enables_reg[BIT_UNCORR_IRQ];
    assign corrIrqEn = enables_reg[BIT_CORR_IRQ];

    // every path looks only at its own enable
    assign pucTrig = uncorrErrDet & rstEn; // RULE1 RULE9
    assign uncorrNmiTrig = uncorrErrDet & uncorrIrqEn; // RULE3 RULE9
    assign corrNmiTrig = corrErrDet & corrIrqEn; // RULE4 RULE9

    // the acknowledge retires the source whose code is on show
    assign ackUncorr = link.nmiAck & pendUncorr_reg;
    assign ackCorr = link.nmiAck & ~pendUncorr_reg & pendCorr_reg;
    assign pendUncorr_next = uncorrNmiTrig | (pendUncorr_reg & ~ackUncorr); // RULE3
    assign pendCorr_next = corrNmiTrig | (pendCorr_reg & ~ackCorr); // RULE4

    // uncorrectable outranks correctable in the vector
    assign nmiVec_next = pendUncorr_next ? NMIVEC_UNCORR : // RULE3
                         pendCorr_next ? NMIVEC_CORR : // RULE4
                         NMIVEC_NONE;

    // clear request is stretched so the system reset logic sees it
    assign pucActive = (pucCnt_reg != PUC_ZERO);
    assign pucCnt_next = pucTrig ? PUC_LOAD :
                         pucActive ? pucCnt_reg - PUC_ONE :
                         PUC_ZERO; // RULE1
    assign pucActiveNext = (pucCnt_next != PUC_ZERO);

    // reading the vector empties it unless a new cause lands that cycle
    assign rstVec_next = pucTrig ? RSTVEC_UNCORR : // RULE2
                         link.rstVecRead ? RSTVEC_NONE :
                         rstVec_reg;

    // address of the most recent error of either kind
    assign anyDetect = |detect;
    assign errAddr_next = anyDetect ? errAddr : errAddr_reg;

    // one event counter per error kind; it saturates so a flood of errors never reads as few
    generate
        for (i = 0; i < FLAG_W; i++)
        begin : g_count
            assign cntFull[i] = &errCnt_reg[i];
            assign errCnt_next[i] = (detect[i] & ~cntFull[i]) ? errCnt_reg[i] + CNT_ONE : errCnt_reg[i];
            always_ff @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                begin
                    errCnt_reg[i] <= '0;
                end
                else
                begin
                    errCnt_reg[i] <= errCnt_next[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            enables_reg <= CTL_A_RESET;
            flags_reg <= FLAG_RESET;
        end
        else
        begin
            enables_reg <= enables_next;
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pendUncorr_reg <= 1'b0;
            pendCorr_reg <= 1'b0;
            nmiVec_reg <= NMIVEC_NONE;
        end
        else
        begin
            pendUncorr_reg <= pendUncorr_next;
            pendCorr_reg <= pendCorr_next;
            nmiVec_reg <= nmiVec_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pucCnt_reg <= PUC_ZERO;
            pucHold_reg <= 1'b0;
            rstVec_reg <= RSTVEC_NONE;
        end
        else
        begin
            pucCnt_reg <= pucCnt_next;
            pucHold_reg <= pucActiveNext;
            rstVec_reg <= rstVec_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            errAddr_reg <= '0;
        end
        else
        begin
            errAddr_reg <= errAddr_next;
        end
    end

    assign link.enables = enables_reg;
    assign link.flags = flags_reg;
    assign nmiPending = pendUncorr_reg | pendCorr_reg;
    assign link.nmiReq = nmiPending;
    assign link.nmiVector = nmiVec_reg;
    assign link.pucReq = pucHold_reg;
    assign link.rstVector = rstVec_reg;
    assign pucHold = pucHold_reg;
    assign lastErrAddr = errAddr_reg;
    assign corrCount = errCnt_reg[FLAG_CORR];
    assign uncorrCount = errCnt_reg[FLAG_UNCORR];
endmodule // nbe_error_report

// ==== logic/nbe_core_end.sv ====
/*
 holds the core-side end: writes enables, clears flags, services the nmi
 vector, reads the reset vector, and sequences low power entry and wake-up.
 assumes user-side requests are synchronous one-cycle pulses on clk_sys.
*/
module nbe_core_end #(
    parameter int MCLK_HZ = nbe_pkg::CLK_HZ
) (
    input wire logic clk_sys,
    input wire logic reset,
    nbe_link_if.core link,
    input wire logic cfgWrite,
    input wire logic [nbe_pkg::CTL_A_W-1:0] cfgData,
    input wire logic [nbe_pkg::FLAG_W-1:0] clearFlags,
    input wire logic lpmEnterReq,
    input wire logic wakeUp,
    input wire logic accessDone,
    input wire logic nmiService,
    input wire logic sysResetSeen,
    output logic lpmReady,
    output logic [nbe_pkg::VEC_W-1:0] nmiCode,
    output logic [nbe_pkg::VEC_W-1:0] resetCause,
    output logic spuriousReset
);
    import nbe_pkg::*;

    typedef enum logic [1:0] {ACTIVE, SLEEP, WAKE_WAIT} nbe_pm_type;

    // the reset enable is withheld when the clock is too fast for it
    localparam logic RST_ALLOWED = (MCLK_HZ <= UNCORR_RST_MAX_HZ); // RULE7
    localparam logic [CTL_A_W-1:0] RST_KEEP = {{(CTL_A_W-1){1'b1}}, RST_ALLOWED};

    nbe_pm_type state_reg;
    nbe_pm_type state_next;
    logic [CTL_A_W-1:0] saved_reg;
    logic [CTL_A_W-1:0] saved_next;
    logic enWrite_reg;
    logic enWrite_next;
    logic [CTL_A_W-1:0] enData_reg;
    logic [CTL_A_W-1:0] enData_next;
    logic [FLAG_W-1:0] clr_reg;
    logic [FLAG_W-1:0] clr_next;
    logic [VEC_W-1:0] nmiCode_reg;
    logic [VEC_W-1:0] cause_reg;
    logic spurious_reg;
    logic [CTL_A_W-1:0] cfgMasked;
    wire nmiAckNow = nmiService & link.nmiReq;

    assign cfgMasked = cfgData & RST_KEEP; // RULE7

    always_comb
    begin
        state_next = state_reg;
        saved_next = cfgWrite ? cfgMasked : saved_reg;
        enWrite_next = 1'b0;
        enData_next = enData_reg;
        clr_next = clearFlags;
        case (state_reg)
            ACTIVE:
            begin
                if (lpmEnterReq)
                begin
                    enWrite_next = 1'b1;
                    enData_next = CTL_A_RESET; // RULE6
                    state_next = SLEEP;
                end
                else if (cfgWrite)
                begin
                    enWrite_next = 1'b1;
                    enData_next = cfgMasked;
                end
            end
            SLEEP:
            begin
                if (wakeUp)
                begin
                    state_next = WAKE_WAIT;
                end
            end
            WAKE_WAIT:
            begin
                if (accessDone)
                begin
                    clr_next = FLAG_ALL; // RULE6
                    enWrite_next = 1'b1;
                    enData_next = saved_next; // RULE6
                    state_next = ACTIVE;
                end
            end
            default:
            begin
                state_next = ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ACTIVE;
            saved_reg <= CTL_A_RESET;
            enWrite_reg <= 1'b0;
            enData_reg <= CTL_A_RESET;
            clr_reg <= FLAG_RESET;
        end
        else
        begin
            state_reg <= state_next;
            saved_reg <= saved_next;
            enWrite_reg <= enWrite_next;
            enData_reg <= enData_next;
            clr_reg <= clr_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            nmiCode_reg <= NMIVEC_NONE;
            cause_reg <= RSTVEC_NONE;
            spurious_reg <= 1'b0;
        end
        else
        begin
            if (nmiAckNow)
            begin
                nmiCode_reg <= link.nmiVector;
            end
            if (sysResetSeen)
            begin
                cause_reg <= link.rstVector;
                spurious_reg <= (link.rstVector == RSTVEC_NONE); // RULE8
            end
        end
    end

    assign link.enWrite = enWrite_reg;
    assign link.enData = enData_reg;
    assign link.flagClear = clr_reg;
    assign link.nmiAck = nmiAckNow;
    assign link.rstVecRead = sysResetSeen;
    assign lpmReady = (state_reg == SLEEP);
    assign nmiCode = nmiCode_reg;
    assign resetCause = cause_reg;
    assign spuriousReset = spurious_reg;
endmodule // nbe_core_end

// ==== verification/nbe_link_properties.sv ====
/*
 assertions on the link between the error-reporting end and the core end.
 assumes it sits beside the link interface, on clk_sys, reset active high.
*/
module nbe_link_properties (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic uncorrErrDet,
    input wire logic corrErrDet,
    input wire logic [nbe_pkg::CTL_A_W-1:0] enables,
    input wire logic [nbe_pkg::FLAG_W-1:0] flags,
    input wire logic [nbe_pkg::FLAG_W-1:0] flagClear,
    input wire logic nmiReq,
    input wire logic [nbe_pkg::VEC_W-1:0] nmiVector,
    input wire logic pucReq,
    input wire logic [nbe_pkg::VEC_W-1:0] rstVector
);
    timeunit 1ns;
    timeprecision 1ns;
    import nbe_pkg::*;
    wire uncRst = uncorrErrDet && enables[BIT_UNCORR_RST];
    wire uncIrq = uncorrErrDet && enables[BIT_UNCORR_IRQ];
    wire corIrq = corrErrDet && enables[BIT_CORR_IRQ];
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    a_puc_hold: assert property (uncRst |=> pucReq [*4])
        else $error("clear request not held");
    a_rst_code: assert property (uncRst |=> rstVector == RSTVEC_UNCORR)
        else $error("reset vector code wrong");
    a_uncorr_nmi: assert property (uncIrq |=> nmiReq && nmiVector == NMIVEC_UNCORR)
        else $error("uncorrectable nmi missing");
    a_corr_nmi: assert property (corIrq |=> nmiReq && nmiVector != NMIVEC_NONE)
        else $error("correctable nmi missing");
    a_flag_sticky: assert property (flags[FLAG_CORR] && !flagClear[FLAG_CORR] |=> flags[FLAG_CORR])
        else $error("flag dropped without clear");
    a_flag_clear: assert property (flagClear[FLAG_UNCORR] && !uncorrErrDet |=> !flags[FLAG_UNCORR])
        else $error("flag not cleared");
    a_flag_set: assert property (uncorrErrDet || corrErrDet |=>
        flags[FLAG_UNCORR] >= $past(uncorrErrDet) && flags[FLAG_CORR] >= $past(corrErrDet))
        else $error("flag not set on error");
    a_puc_cause: assert property ($rose(pucReq) |-> $past(uncRst))
        else $error("clear request without cause");
    a_nmi_cause: assert property ($rose(nmiReq) |-> $past(uncIrq || corIrq))
        else $error("nmi without cause");
    cover property (uncRst);
    cover property (nmiReq && nmiVector == NMIVEC_CORR);
    cover property (flagClear[FLAG_UNCORR] && uncorrErrDet);
endmodule // nbe_link_properties

// ==== verification/tb_nvram_bit_error_reporting.sv ====
/*
 self-checking bench: error-reporting end and core end joined by the link.
 assumes clk_sys at 20 MHz; one core end is built for a 12 MHz clock, a second one
 for the default clock on a tied-off link, so that its reset enable is masked.
*/
module tb_nvram_bit_error_reporting;
    timeunit 1ns;
    timeprecision 1ns;
    import nbe_pkg::*;
    typedef struct packed {
        logic [CTL_A_W-1:0] en;
        logic u;
        logic c;
        logic [VEC_W-1:0] vec;
        logic power_up_clear;
    } nbe_row_type;
    nbe_row_type rows [6] = '{'{3'h0, 1'b1, 1'b0, NMIVEC_NONE, 1'b0}, '{3'h1, 1'b1, 1'b0, NMIVEC_NONE, 1'b1},
        '{3'h2, 1'b1, 1'b0, NMIVEC_UNCORR, 1'b0}, '{3'h4, 1'b0, 1'b1, NMIVEC_CORR, 1'b0},
        '{3'h7, 1'b1, 1'b1, NMIVEC_UNCORR, 1'b1}, '{3'h3, 1'b0, 1'b1, NMIVEC_NONE, 1'b0}};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic corrErrDet = 1'b0, uncorrErrDet = 1'b0, cfgWrite = 1'b0;
    logic [ADDR_W-1:0] errAddr = 16'h00a5;
    logic [CTL_A_W-1:0] cfgData = 3'h0;
    logic [FLAG_W-1:0] clearFlags = 2'h0;
    logic lpmEnterReq = 1'b0, wakeUp = 1'b0, accessDone = 1'b0, nmiService = 1'b0, sysResetSeen = 1'b0;
    logic pucHold, lpmReady, spuriousReset;
    logic [ADDR_W-1:0] lastErrAddr;
    logic [ERR_CNT_W-1:0] corrCount, uncorrCount;
    logic [VEC_W-1:0] nmiCode, resetCause;
    int mismatches = 0, num_checks = 0;
    nbe_link_if link();
    nbe_error_report i_nbe_error_report (.clk_sys(clk_sys), .reset(reset), .link(link),
        .corrErrDet(corrErrDet), .uncorrErrDet(uncorrErrDet), .errAddr(errAddr), .pucHold(pucHold),
        .lastErrAddr(lastErrAddr), .corrCount(corrCount), .uncorrCount(uncorrCount));
    nbe_core_end #(.MCLK_HZ(UNCORR_RST_MAX_HZ)) i_nbe_core_end (.clk_sys(clk_sys), .reset(reset),
        .link(link), .cfgWrite(cfgWrite), .cfgData(cfgData), .clearFlags(clearFlags),
        .lpmEnterReq(lpmEnterReq), .wakeUp(wakeUp), .accessDone(accessDone), .nmiService(nmiService),
        .sysResetSeen(sysResetSeen), .lpmReady(lpmReady), .nmiCode(nmiCode), .resetCause(resetCause),
        .spuriousReset(spuriousReset));
    // second core end at the default clock; its link answers nothing
    nbe_link_if linkFast();
    assign linkFast.enables = CTL_A_RESET;
    assign linkFast.flags = FLAG_RESET;
    assign linkFast.nmiReq = 1'b0;
    assign linkFast.nmiVector = NMIVEC_NONE;
    assign linkFast.pucReq = 1'b0;
    assign linkFast.rstVector = RSTVEC_NONE;
    nbe_core_end i_nbe_core_end_fast (.clk_sys(clk_sys), .reset(reset), .link(linkFast), .cfgWrite(cfgWrite),
        .cfgData(cfgData), .clearFlags(clearFlags), .lpmEnterReq(lpmEnterReq), .wakeUp(wakeUp),
        .accessDone(accessDone), .nmiService(nmiService), .sysResetSeen(sysResetSeen), .lpmReady(),
        .nmiCode(), .resetCause(), .spuriousReset());
    nbe_link_properties i_nbe_link_properties (.clk_sys(clk_sys), .reset(reset),
        .uncorrErrDet(uncorrErrDet), .corrErrDet(corrErrDet), .enables(link.enables), .flags(link.flags),
        .flagClear(link.flagClear), .nmiReq(link.nmiReq), .nmiVector(link.nmiVector),
        .pucReq(link.pucReq), .rstVector(link.rstVector));
    initial forever #25 clk_sys = ~clk_sys;
    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
        num_checks++;
        if (got !== expv)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic cfg(input logic [CTL_A_W-1:0] v);
        cfgWrite <= 1'b1;
        cfgData <= v;
        tick(1);
        cfgWrite <= 1'b0;
        tick(2);
    endtask
    initial
    begin
        tick(3);
        reset <= 1'b0;
        #1;
        chk("enables", CTL_A_RESET, link.enables);
        chk("flags", FLAG_RESET, link.flags);
        foreach (rows[i])
        begin
            cfg(rows[i].en);
            uncorrErrDet <= rows[i].u;
            corrErrDet <= rows[i].c;
            tick(1);
            uncorrErrDet <= 1'b0;
            corrErrDet <= 1'b0;
            nmiService <= 1'b1;
            sysResetSeen <= 1'b1;
            clearFlags <= FLAG_ALL;
            #1;
            chk("flags", {rows[i].c, rows[i].u}, link.flags);
            chk("nmi vector", rows[i].vec, link.nmiVector);
            chk("clear request", rows[i].power_up_clear, pucHold);
            chk("error address", 16'h00a5, lastErrAddr);
            tick(1);
            nmiService <= 1'b0;
            sysResetSeen <= 1'b0;
            #1;
            chk("reset cause", rows[i].power_up_clear ? RSTVEC_UNCORR : RSTVEC_NONE, resetCause);
            chk("spurious", !rows[i].power_up_clear, spuriousReset);
            tick(1);
            #1;
            if (rows[i].vec != NMIVEC_NONE)
                chk("nmi code", rows[i].vec, nmiCode);
            nmiService <= 1'b1;
            tick(3);
            nmiService <= 1'b0;
            clearFlags <= 2'h0;
            tick(3);
            #1;
            chk("nmi retired", 1'b0, link.nmiReq);
            chk("flags cleared", FLAG_RESET, link.flags);
        end
        // detect in the clearing cycle keeps the flag
        clearFlags <= 2'h1;
        tick(1);
        clearFlags <= 2'h0;
        uncorrErrDet <= 1'b1;
        tick(1);
        uncorrErrDet <= 1'b0;
        #1;
        chk("set over clear", 1'b1, link.flags[FLAG_UNCORR]);
        cfg(3'h7);
        #1;
        chk("fast enable data", 3'h6, linkFast.enData);
        lpmEnterReq <= 1'b1;
        tick(1);
        lpmEnterReq <= 1'b0;
        tick(2);
        #1;
        chk("lpm ready", 1'b1, lpmReady);
        chk("enables asleep", 3'h0, link.enables);
        corrErrDet <= 1'b1;
        errAddr <= 16'h0c3e;
        tick(1);
        corrErrDet <= 1'b0;
        wakeUp <= 1'b1;
        #1;
        chk("flag asleep", 1'b1, link.flags[FLAG_CORR]);
        chk("error address", 16'h0c3e, lastErrAddr);
        tick(1);
        wakeUp <= 1'b0;
        accessDone <= 1'b1;
        tick(1);
        accessDone <= 1'b0;
        tick(2);
        #1;
        chk("flags after wake", FLAG_RESET, link.flags);
        chk("enables restored", 3'h7, link.enables);
        chk("fast enables restored", 3'h6, linkFast.enData);
        chk("uncorrectable count", 8'h05, uncorrCount);
        chk("correctable count", 8'h04, corrCount);
        uncorrErrDet <= 1'b1;
        tick(1);
        uncorrErrDet <= 1'b0;
        tick(1);
        reset <= 1'b1;
        #1;
        chk("clear request in reset", 1'b0, pucHold);
        chk("reset vector in reset", RSTVEC_NONE, link.rstVector);
        chk("nmi in reset", 1'b0, link.nmiReq);
        tick(2);
        reset <= 1'b0;
        tick(2);
        #1;
        chk("enables after reset", CTL_A_RESET, link.enables);
        chk("counts after reset", 16'h0000, {corrCount, uncorrCount});
        chk("address after reset", 16'h0000, lastErrAddr);
        end_sim();
    end
    initial
    begin
        tick(400);
        mismatches++;
        end_sim();
    end
endmodule // tb_nvram_bit_error_reporting
